/* File: src/mcc_ctrl.v */
/*
 * Memory controller access sequencer: page-hit detection, DRAM column
 * strobe timing with delayed write, SRAM burst-type cycle length,
 * burst inhibit, parity qualification, and refresh request timing.
 * Assumes access requests synchronous to mclk_i, held until done_o.
 */
// What this block does
// - Page size code selects compared address lines
// - Delayed write adds clock to page-hit writes
// - Without delayed write, reads equal writes
// - Delayed write applies to internal and external masters
// - Burst SRAM cycle is count plus two, plus setup
// - No parity check when external ack is high at access end
// - Early strobe negate ignores synchronous bus setting
// - Burst ack off asserts burst inhibit
// - Option one bits 3:2 reset to zero, loaded from config pins on first clock
// - Refresh period is (count+1) times sixteen clocks
// - DRAM cycle table means total clocks
// - Chip select asserted with relax, negate, zero count
// - Burst-type external master unsupported in master mode
`timescale 1ns/100ps
`include "mcc_defs.vh"

module mcc_ctrl (
    input  wire                    mclk_i,
    input  wire                    nrst_i,
    input  wire                    req_i,
    input  wire                    write_i,
    input  wire                    is_dram_i,
    input  wire                    ext_master_i,
    input  wire                    ext_burst_type_i,
    input  wire                    master_mode_i,
    input  wire                    port16_i,
    input  wire [`MCC_ADDR_W-1:0]  addr_i,
    input  wire                    ext_ack_i,
    input  wire                    parity_enable_i,
    input  wire [`MCC_PGS_W-1:0]   page_size_select_i,
    input  wire                    page_mode_enable_i,
    input  wire                    delay_write_extra_i,
    input  wire [`MCC_CYCLE_LENGTH_COUNT_W-1:0]  cycle_length_count_i,
    input  wire                    access_setup_extra_i,
    input  wire                    early_strobe_negate_i,
    input  wire                    sync_bus_i,
    input  wire                    burst_ack_enable_i,
    input  wire                    timing_relax_i,
    input  wire                    strobe_negate_timing_i,
    input  wire [1:0]              config_pins_i,
    input  wire                    or1_write_i,
    input  wire [1:0]              or1_wdata_i,
    input  wire                    refresh_enable_i,
    input  wire [`MCC_REFRESH_PERIOD_COUNT_W-1:0]  refresh_period_count_i,
    output wire                    ready_o,
    output reg                     done_o,
    output reg                     chip_select_o,
    output reg                     col_strobe_o,
    output reg                     burst_inhibit_o,
    output reg                     parity_check_o,
    output reg                     page_hit_o,
    output reg                     unsupported_o,
    output reg  [`MCC_LEN_W-1:0]   cycle_len_o,
    output reg  [1:0]              or1_bits_o,
    output wire                    refresh_req_o
);

// ****************************************************************
// States
// ****************************************************************
localparam ST_IDLE = 2'b00;
localparam ST_RUN  = 2'b01;
localparam ST_DONE = 2'b10;

reg  [1:0]              state_reg;
reg  [1:0]              state_next;
reg  [`MCC_LEN_W-1:0]   count_reg;
reg  [`MCC_LEN_W-1:0]   len_reg;
reg  [`MCC_LEN_W-1:0]   len_next;
reg  [`MCC_LEN_W-1:0]   strobe_on;
reg  [`MCC_LEN_W-1:0]   strobe_off;
reg  [`MCC_ADDR_W-1:0]  last_addr_reg;
reg                     last_valid_reg;
reg                     or1_loaded_reg;
reg                     wr_reg;
reg                     dram_reg;
reg                     dly_reg;
wire [`MCC_ADDR_W-1:0]  page_mask;
wire                    hit_now;
wire                    refuse;
wire                    take_now;
wire                    dly_now;
wire [4:0]              low_line;

// ****************************************************************
// Page compare mask, one generate step per address line
// ****************************************************************
// Codes pair up: 000 alone, then 001/010, 011/100, 101/110, 111
assign low_line = (port16_i ? 5'd`MCC_PG_BASE16 : 5'd`MCC_PG_BASE32)
                + {1'b0, ({1'b0, page_size_select_i} + 4'h1) >> 1};

genvar gi;
generate
    for (gi = 0; gi < `MCC_ADDR_W; gi = gi + 1) begin : g_mask
        assign page_mask[gi] = (gi >= low_line) && (gi <= `MCC_PG_TOP);
    end
endgenerate

assign hit_now = is_dram_i && page_mode_enable_i && last_valid_reg
               && (((addr_i ^ last_addr_reg) & page_mask) == {`MCC_ADDR_W{1'b0}});

// Burst-type external master in master mode is not served
assign refuse  = ext_master_i && ext_burst_type_i && master_mode_i;
assign take_now = (state_reg == ST_IDLE) && req_i && !refuse;
assign dly_now  = is_dram_i && write_i && hit_now && delay_write_extra_i;
assign ready_o = (state_reg == ST_IDLE);

// ****************************************************************
// Cycle length
// ****************************************************************
always @* begin
    len_next = {1'b0, cycle_length_count_i} + `MCC_SRAM_BASE;
    if (is_dram_i) begin
        // Count plus one is total clocks for the access, not count plus added waits
        len_next = {1'b0, cycle_length_count_i} + 5'h01;
        // Extra clock only on page-hit writes, any master
        if (write_i && hit_now && delay_write_extra_i) begin
            len_next = len_next + `MCC_DRAM_WR_EXTRA;
        end // else reads and writes match
    end else if (ext_master_i && ext_burst_type_i) begin
        len_next = {1'b0, cycle_length_count_i} + `MCC_SRAM_BASE
                 + {4'h0, access_setup_extra_i};
    end
end

// Column strobe window, shifted one clock by delayed write
always @* begin
    strobe_on  = dly_reg ? 5'h01 : 5'h00;
    strobe_off = dly_reg ? len_reg : len_reg - 5'h01;
end

// ****************************************************************
// Sequencer
// ****************************************************************
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (req_i && !refuse) begin
                state_next = ST_RUN;
            end
        end
        ST_RUN: begin
            if (count_reg + 5'h01 >= len_reg) begin
                state_next = ST_DONE;
            end
        end
        ST_DONE: state_next = ST_IDLE;
        default: state_next = ST_IDLE;
    endcase
end

always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        state_reg       <= ST_IDLE;
        count_reg       <= 5'h00;
        len_reg         <= 5'h01;
        last_addr_reg   <= {`MCC_ADDR_W{1'b0}};
        last_valid_reg  <= 1'b0;
        wr_reg          <= 1'b0;
        dram_reg        <= 1'b0;
        dly_reg         <= 1'b0;
        done_o          <= 1'b0;
        chip_select_o   <= 1'b0;
        col_strobe_o    <= 1'b0;
        burst_inhibit_o <= 1'b0;
        parity_check_o  <= 1'b0;
        page_hit_o      <= 1'b0;
        unsupported_o   <= 1'b0;
        cycle_len_o     <= 5'h00;
    end else begin
        state_reg     <= state_next;
        done_o        <= 1'b0;
        unsupported_o <= (state_reg == ST_IDLE) && req_i && refuse;
        case (state_reg)
            ST_IDLE: begin
                count_reg <= 5'h00;
                if (req_i && !refuse) begin
                    len_reg       <= len_next;
                    cycle_len_o   <= len_next;
                    page_hit_o    <= hit_now;
                    wr_reg        <= write_i;
                    dram_reg      <= is_dram_i;
                    dly_reg       <= dly_now;
                    // Asserted whatever relax/negate/count combine to
                    chip_select_o <= 1'b1;
                    burst_inhibit_o <= !burst_ack_enable_i;
                    if (is_dram_i) begin
                        last_addr_reg  <= addr_i;
                        last_valid_reg <= 1'b1;
                    end
                end
            end
            ST_RUN: begin
                count_reg <= count_reg + 5'h01;
                // Early negate acts without regard to sync_bus_i
                if (early_strobe_negate_i && !timing_relax_i
                    && (count_reg + 5'h02 >= len_reg)) begin
                    chip_select_o <= 1'b0;
                end
                if (state_next == ST_DONE) begin
                    done_o         <= 1'b1;
                    // Externally acknowledged ends are never parity checked
                    parity_check_o <= parity_enable_i && !ext_ack_i
                                      && !wr_reg;
                end
            end
            ST_DONE: begin
                chip_select_o   <= 1'b0;
                burst_inhibit_o <= 1'b0;
                parity_check_o  <= 1'b0;
            end
            default: chip_select_o <= 1'b0;
        endcase
        // First strobe clock is decided from the take itself, so the window
        // of one access never leaks into the first clock of the next
        if (take_now) begin
            col_strobe_o <= is_dram_i && !dly_now && (len_next > 5'h01);
        end else begin
            col_strobe_o <= dram_reg && (state_reg == ST_RUN) && (state_next == ST_RUN)
                            && (count_reg + 5'h01 >= strobe_on)
                            && (count_reg + 5'h01 < strobe_off);
        end
    end
end

// ****************************************************************
// Option register 1 bits 3:2, loaded from pins after reset
// ****************************************************************
// Async reset takes a constant; the pins are caught on the first edge
always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        or1_loaded_reg <= 1'b0;
        or1_bits_o     <= 2'b00;
    end else if (!or1_loaded_reg) begin
        or1_loaded_reg <= 1'b1;
        or1_bits_o     <= config_pins_i;
    end else if (or1_write_i) begin
        or1_bits_o <= or1_wdata_i;
    end
end

// ****************************************************************
// Refresh timer
// ****************************************************************
mcc_refresh u_refresh (
    .mclk_i                 (mclk_i),
    .nrst_i                 (nrst_i),
    .enable_i               (refresh_enable_i),
    .refresh_period_count_i (refresh_period_count_i),
    .refresh_req_o          (refresh_req_o)
);

endmodule // mcc_ctrl

/* File: src/mcc_defs.vh */
/*
 * Constants for the memory controller corrections block: field widths,
 * cycle figures, refresh prescale and option register 1 bit positions.
 * Assumes inclusion by bare name from the design files under src/.
 */
`ifndef MCC_DEFS_VH
`define MCC_DEFS_VH

// ****************************************************************
// Field widths
// ****************************************************************
`define MCC_ADDR_W          26
`define MCC_PGS_W           3
`define MCC_CYCLE_LENGTH_COUNT_W          4
`define MCC_REFRESH_PERIOD_COUNT_W          8
`define MCC_LEN_W           5

// ****************************************************************
// Page compare: lowest compared address line for code 000, and highest compared line
// ****************************************************************
`define MCC_PG_BASE32       10
`define MCC_PG_BASE16       9
`define MCC_PG_TOP          25

// ****************************************************************
// Timing figures
// ****************************************************************
`define MCC_REF_PRESCALE    16
`define MCC_SRAM_BASE       5'h02
`define MCC_DRAM_WR_EXTRA   5'h01

// ****************************************************************
// Option register 1 bits 3 and 2
// ****************************************************************
`define MCC_OR1_HI_BIT      3
`define MCC_OR1_LO_BIT      2

`endif

/* File: src/mcc_refresh.v */
/*
 * Refresh request timer for the memory controller.
 * Assumes one system clock and a synchronous enable from the controller.
 */
`timescale 1ns/100ps
`include "mcc_defs.vh"

module mcc_refresh (
    input  wire                    mclk_i,
    input  wire                    nrst_i,
    input  wire                    enable_i,
    input  wire [`MCC_REFRESH_PERIOD_COUNT_W-1:0]  refresh_period_count_i,
    output reg                     refresh_req_o
);

// ****************************************************************
// Prescaler: one tick every sixteen clocks
// ****************************************************************
reg  [3:0]              pre_reg;
reg  [`MCC_REFRESH_PERIOD_COUNT_W-1:0]  cnt_reg;
wire                    tick;

assign tick = (pre_reg == 4'hF);

always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        pre_reg       <= 4'h0;
        cnt_reg       <= {`MCC_REFRESH_PERIOD_COUNT_W{1'b0}};
        refresh_req_o <= 1'b0;
    end else if (!enable_i) begin
        pre_reg       <= 4'h0;
        cnt_reg       <= {`MCC_REFRESH_PERIOD_COUNT_W{1'b0}};
        refresh_req_o <= 1'b0;
    end else begin
        pre_reg       <= pre_reg + 4'h1;
        refresh_req_o <= 1'b0;
        if (tick) begin
            // Period is (count + 1) * 16 clocks
            if (cnt_reg >= refresh_period_count_i) begin
                cnt_reg       <= {`MCC_REFRESH_PERIOD_COUNT_W{1'b0}};
                refresh_req_o <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + {{(`MCC_REFRESH_PERIOD_COUNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
end

endmodule // mcc_refresh

/* File: verification/mcc_ctrl_props.sv */
/* Assertion checker for mcc_ctrl, watching its ports only.
   Assumes one clock domain and bench inputs held until ready_o returns. */
`timescale 1ns/100ps
`include "mcc_defs.vh"
module mcc_ctrl_props (
    input wire                   mclk_i,
    input wire                   nrst_i,
    input wire                   req_i,
    input wire                   ready_o,
    input wire                   ext_master_i,
    input wire                   ext_burst_type_i,
    input wire                   master_mode_i,
    input wire                   is_dram_i,
    input wire                   timing_relax_i,
    input wire                   burst_ack_enable_i,
    input wire                   ext_ack_i,
    input wire                   refresh_enable_i,
    input wire [`MCC_REFRESH_PERIOD_COUNT_W-1:0] refresh_period_count_i,
    input wire                   chip_select_o,
    input wire                   col_strobe_o,
    input wire                   burst_inhibit_o,
    input wire                   done_o,
    input wire                   parity_check_o,
    input wire                   unsupported_o,
    input wire                   refresh_req_o,
    input wire [`MCC_LEN_W-1:0]  cycle_len_o
);
    wire        take = ready_o && req_i;
    wire        bad  = ext_master_i && ext_burst_type_i && master_mode_i;
    reg  [12:0] gap_reg;
    reg         seen_reg;
    reg  [4:0]  run_reg;
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_reg  <= 13'h0000;
            seen_reg <= 1'b0;
            run_reg  <= 5'h00;
        end else begin
            gap_reg  <= refresh_req_o ? 13'h0001 : gap_reg + 13'h0001;
            seen_reg <= refresh_enable_i && (seen_reg || refresh_req_o);
            run_reg  <= (take && !bad) ? 5'h00 : run_reg + 5'h01;
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    a_refused_no_access: assert property (take && bad |=> unsupported_o && !chip_select_o)
        else $error("refused request started an access");
    a_unsup_only_idle: assert property (unsupported_o |-> ready_o && !done_o)
        else $error("refusal pulse outside idle");
    a_cs_relax_zero: assert property (take && !bad && timing_relax_i |=> chip_select_o)
        else $error("chip select missing after relaxed take");
    a_burst_inhibit_set: assert property ($rose(chip_select_o) |-> burst_inhibit_o == !burst_ack_enable_i)
        else $error("burst inhibit wrong at access start");
    a_parity_ext_ack: assert property (done_o && $past(ext_ack_i) |-> !parity_check_o ##1 !parity_check_o)
        else $error("parity checked on external ack");
    a_col_strobe_dram: assert property (col_strobe_o |-> is_dram_i)
        else $error("column strobe on non-DRAM access");
    a_refresh_period: assert property (refresh_req_o && seen_reg |-> gap_reg == ({5'h00, refresh_period_count_i} + 13'h0001) * 13'h0010)
        else $error("refresh period wrong");
    a_len_total_clk: assert property (done_o |-> run_reg == cycle_len_o)
        else $error("access length differs from reported length");
endmodule // mcc_ctrl_props
bind mcc_ctrl mcc_ctrl_props i_props (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i),
    .ready_o(ready_o), .ext_master_i(ext_master_i), .ext_burst_type_i(ext_burst_type_i),
    .master_mode_i(master_mode_i), .is_dram_i(is_dram_i), .timing_relax_i(timing_relax_i),
    .burst_ack_enable_i(burst_ack_enable_i), .ext_ack_i(ext_ack_i),
    .refresh_enable_i(refresh_enable_i), .refresh_period_count_i(refresh_period_count_i),
    .chip_select_o(chip_select_o), .col_strobe_o(col_strobe_o), .done_o(done_o),
    .burst_inhibit_o(burst_inhibit_o), .parity_check_o(parity_check_o),
    .unsupported_o(unsupported_o), .refresh_req_o(refresh_req_o), .cycle_len_o(cycle_len_o));

/* File: verification/mcc_mem_model.sv */
/* Far-side memory model: terminates external-master cycles by ack.
   Assumes the bench picks per access whether the ack is given. */
`timescale 1ns/100ps
module mcc_mem_model (
    input  wire mclk_i,
    input  wire nrst_i,
    input  wire chip_select_i,
    input  wire ext_master_i,
    input  wire ack_mode_i,
    output reg  ext_ack_o
);
    // Ack follows select one clock late, so a stale ack never ends a later access
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) ext_ack_o <= 1'b0;
        else ext_ack_o <= chip_select_i && ext_master_i && ack_mode_i;
    end
endmodule // mcc_mem_model

/* File: verification/tb_top.sv */
/* Self-checking bench for mcc_ctrl with the memory model.
   Assumes the design holds each access until done_o as handed over. */
`timescale 1ns/100ps
module tb_top;
    reg mclk_i = 0, nrst_i = 0, req = 0, wr = 0, dram = 0, em = 0, ebt = 0, mm = 0, p16 = 0;
    reg pe = 0, pme = 0, dwe = 0, ase = 0, esn = 0, sb = 0, bae = 0, tr = 0, snt = 0;
    reg or1w = 0, refen = 0, ackm = 0, lastv = 0;
    reg [25:0] addr = 0, last = 0;
    reg [2:0]  pgs = 0;
    reg [3:0]  cycle_length_count = 0;
    reg [1:0]  cfg = 2'h2, or1d = 0;
    reg [7:0]  refresh_period_count = 0;
    reg [15:0] lfsr = 16'h0031;
    wire       ready, done, cs, cas, bi, pc, ph, uns, refq, ack;
    wire [4:0] len;
    wire [1:0] or1b;
    integer    miscompares = 0, samples_checked = 0, cyc = 0, i, n, b, ncas;
    reg        h;
    always #2 mclk_i = ~mclk_i;
    mcc_ctrl i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req), .write_i(wr), .is_dram_i(dram),
        .ext_master_i(em), .ext_burst_type_i(ebt), .master_mode_i(mm), .port16_i(p16),
        .addr_i(addr), .ext_ack_i(ack), .parity_enable_i(pe), .page_size_select_i(pgs),
        .page_mode_enable_i(pme), .delay_write_extra_i(dwe), .cycle_length_count_i(cycle_length_count),
        .access_setup_extra_i(ase), .early_strobe_negate_i(esn), .sync_bus_i(sb),
        .burst_ack_enable_i(bae), .timing_relax_i(tr), .strobe_negate_timing_i(snt),
        .config_pins_i(cfg), .or1_write_i(or1w), .or1_wdata_i(or1d), .refresh_enable_i(refen),
        .refresh_period_count_i(refresh_period_count), .ready_o(ready), .done_o(done), .chip_select_o(cs),
        .col_strobe_o(cas), .burst_inhibit_o(bi), .parity_check_o(pc), .page_hit_o(ph),
        .unsupported_o(uns), .cycle_len_o(len), .or1_bits_o(or1b), .refresh_req_o(refq));
    mcc_mem_model i_mem (.mclk_i(mclk_i), .nrst_i(nrst_i), .chip_select_i(cs), .ext_master_i(em),
        .ack_mode_i(ackm), .ext_ack_o(ack));
    function [15:0] nxt(input [15:0] v);
        nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function [4:0] exp_len(input hit);
        exp_len = dram ? cycle_length_count + 5'h01 + (hit & wr & dwe) : cycle_length_count + 5'h02 + (em & ebt & ase);
    endfunction
    function exp_hit(input dummy);
        integer k;
        k = (p16 ? 9 : 10) + (({1'b0, pgs} + 4'h1) >> 1);
        exp_hit = dram && pme && lastv && ((addr >> k) == (last >> k));
    endfunction
    task chk(input [63:0] seen, input [63:0] exp, input [8*10-1:0] name);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch %0s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task reset_dut;
        nrst_i = 0;
        lastv = 0;
        repeat (8) @(negedge mclk_i);
        nrst_i = 1;
        @(negedge mclk_i);
        chk(or1b, cfg, "or1_reset");
    endtask
    task access;
        h = exp_hit(0);
        req = 1;
        n = 0;
        @(negedge mclk_i);
        chk(len, exp_len(h), "cycle_len");
        chk(ph, h, "page_hit");
        chk(cas, dram && !(h && wr && dwe) && exp_len(h) > 1, "cas_first");
        chk(bi, !bae, "burst_inh");
        ncas = cas;
        while (done !== 1'b1 && n < 40) begin
            @(negedge mclk_i);
            n = n + 1;
            ncas = ncas + cas;
        end
        chk(done, 1, "done");
        chk(pc, pe && !wr && !(em && ackm && exp_len(h) > 1), "parity");
        chk(ncas, dram ? exp_len(h) - 1 : 0, "cas_count");
        // Early negate drops select in the last clock, sync setting aside
        if (exp_len(h) > 1) chk(cs, !(esn && !tr), "cs_early");
        req = 0;
        if (dram) {lastv, last} = {1'b1, addr};
        while (ready !== 1'b1 && n < 80) begin
            @(negedge mclk_i);
            n = n + 1;
        end
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    initial begin
        reset_dut;
        // Page boundary per code: bit below compare keeps hit, lowest compared bit misses
        {dram, pme, wr, dwe} = 4'hF;
        for (i = 0; i < 16; i = i + 1) begin
            {p16, pgs} = i;
            b = (p16 ? 9 : 10) + ((pgs + 1) >> 1);
            addr = 26'h2A5B3C7 ^ i;
            access;
            addr = addr ^ (26'h1 << (b - 1));
            access;
            addr = addr ^ (26'h1 << b);
            access;
        end
        {tr, snt, cycle_length_count} = 6'h30;
        access;
        for (i = 0; i < 60; i = i + 1) begin
            lfsr = nxt(lfsr);
            {wr, dram, em, ebt, p16, pe, pme, dwe, ase, esn, sb, bae, tr, snt, ackm} = lfsr[14:0];
            lfsr = nxt(lfsr);
            {pgs, cycle_length_count} = lfsr[6:0];
            if (pme && cycle_length_count == 4'h0) dwe = 1'b1;
            lfsr = nxt(lfsr);
            addr = lfsr[7] ? last ^ lfsr[8:0] : {lfsr[9:0], lfsr};
            access;
        end
        {em, ebt, mm, req} = 4'hF;
        repeat (2) @(negedge mclk_i);
        chk(uns, 1, "refused");
        chk(cs, 0, "refused_cs");
        {em, ebt, mm, req} = 4'h0;
        or1d = 2'h1;
        or1w = 1;
        @(negedge mclk_i);
        or1w = 0;
        @(negedge mclk_i);
        chk(or1b, 2'h1, "or1_write");
        for (i = 0; i < 2; i = i + 1) begin
            refresh_period_count = i * 3;
            refen = 1;
            n = 0;
            while (refq !== 1'b1 && n < 200) begin
                @(negedge mclk_i);
                n = n + 1;
            end
            n = 0;
            do begin
                @(negedge mclk_i);
                n = n + 1;
            end while (refq !== 1'b1 && n < 200);
            chk(n, (refresh_period_count + 1) * 16, "ref_period");
            refen = 0;
            @(negedge mclk_i);
        end
        cfg = 2'h1;
        reset_dut;
        final_report;
    end
endmodule // tb_top
